/* File: stm_timer.sv */
// Standard timer mode logic with APB register slave
module stm_timer #(
  parameter int CNT_W = stm_pkg::CNT_W
) (
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic        tick_i,
  input  wire logic        external_clock_pin_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             timer_out_o,
  output logic             timer_out_en_o,
  output logic             match_a_flag_o,
  output logic             match_p_flag_o
);

  //------------------------------------------------------------
  // Register state
  //------------------------------------------------------------
  logic [7:0]       ctrl0_q;
  logic [7:0]       ctrl1_q;
  logic [7:0]       cmpa_lo_q;
  logic [1:0]       cmpa_hi_q;
  logic [CNT_W-1:0] cnt_q;
  logic             run_q;
  logic             run_prev_q;
  logic             af_q;
  logic             pf_q;
  logic             pin_q;
  logic             pwm_q;
  logic             ext_s1_q;
  logic             ext_s2_q;
  logic             ext_s3_q;

  //------------------------------------------------------------
  // Field decode
  //------------------------------------------------------------
  wire logic [1:0] mode_sel  = ctrl1_q[stm_pkg::CTRL1_MODE_LSB +: 2];
  wire logic [1:0] out_act   = ctrl1_q[stm_pkg::CTRL1_ACT_LSB +: 2];
  wire logic       init_lvl  = ctrl1_q[stm_pkg::CTRL1_INIT_BIT];
  wire logic       out_inv   = ctrl1_q[stm_pkg::CTRL1_INV_BIT];
  wire logic       swap      = ctrl1_q[stm_pkg::CTRL1_SWAP_BIT];
  wire logic       clr_sel   = ctrl1_q[stm_pkg::CTRL1_CLR_BIT];
  wire logic [2:0] cmpp      = ctrl0_q[stm_pkg::CTRL0_CMPP_LSB +: stm_pkg::CMPP_W];
  wire logic [CNT_W-1:0] cmpa = {cmpa_hi_q, cmpa_lo_q};

  // Mode decode
  wire logic is_cmp   = (mode_sel == stm_pkg::MODE_CMP);
  wire logic is_timer = (mode_sel == stm_pkg::MODE_TIMER);
  wire logic is_m10   = (mode_sel == stm_pkg::MODE_PWM);
  wire logic is_pulse = is_m10 && (out_act == stm_pkg::ACT_PULSE);
  wire logic is_pwm   = is_m10 && !is_pulse;
  wire logic cmp_like = is_cmp || is_timer;

  //------------------------------------------------------------
  // APB decode
  //------------------------------------------------------------
  wire logic wr_en   = psel_i && penable_i && pwrite_i;
  wire logic hit_c0  = (paddr_i == stm_pkg::ADDR_CTRL0);
  wire logic hit_c1  = (paddr_i == stm_pkg::ADDR_CTRL1);
  wire logic hit_clo = (paddr_i == stm_pkg::ADDR_CNT_LO);
  wire logic hit_chi = (paddr_i == stm_pkg::ADDR_CNT_HI);
  wire logic hit_alo = (paddr_i == stm_pkg::ADDR_CMPA_LO);
  wire logic hit_ahi = (paddr_i == stm_pkg::ADDR_CMPA_HI);
  wire logic hit_st  = (paddr_i == stm_pkg::ADDR_STATUS);
  wire logic mapped  = hit_c0 | hit_c1 | hit_clo | hit_chi | hit_alo | hit_ahi | hit_st;
  wire logic wr_c0   = wr_en && hit_c0;
  wire logic wr_st   = wr_en && hit_st;

  // Slave answers in the access cycle; unmapped access reports an error
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  //------------------------------------------------------------
  // Comparators
  //------------------------------------------------------------
  // Comparators stay blind in the run rise cycle, when the count is still stale
  wire logic cnt_live = run_q && run_prev_q && tick_i;
  // Compare P matches the top three counter bits, with all lower counter bits zero
  wire logic match_a = cnt_live && (cnt_q == cmpa);
  wire logic match_p = cnt_live && (cmpp != 3'h0)
                       && (cnt_q[CNT_W-1 -: 3] == cmpp) && (cnt_q[CNT_W-4:0] == '0);
  wire logic ovf     = cnt_live && (&cnt_q);

  // Period and duty selection for PWM
  wire logic [CNT_W-1:0] p_scaled = {cmpp, {(CNT_W-3){1'b0}}};
  wire logic [CNT_W:0]   p_full   = (cmpp == 3'h0) ? (CNT_W+1)'(1 << CNT_W)
                                                   : {1'b0, p_scaled};
  wire logic [CNT_W:0]   a_full   = (cmpa == '0) ? (CNT_W+1)'(1 << CNT_W)
                                                 : {1'b0, cmpa};
  wire logic [CNT_W:0]   period   = swap ? a_full : p_full;
  wire logic [CNT_W:0]   duty     = swap ? p_full : {1'b0, cmpa};
  wire logic period_end = cnt_live
                          && ({1'b0, cnt_q} == period - (CNT_W+1)'(1));
  // PWM P event lands on the last count of the P value, where the counter clears unless swap makes A the period
  wire logic pwm_p_hit  = cnt_live
                          && ({1'b0, cnt_q} == p_full - (CNT_W+1)'(1));

  // Counter clear source per mode
  wire logic cnt_clear = is_pwm   ? period_end
                       : is_pulse ? 1'b0
                       : clr_sel  ? match_a
                       : (match_p || (cmpp == 3'h0 && ovf));

  // Flag events per mode
  wire logic set_af = match_a;
  wire logic set_pf = is_pwm ? pwm_p_hit
                    : (match_p && !is_pulse && !clr_sel);

  //------------------------------------------------------------
  // External trigger synchroniser
  //------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= external_clock_pin_i;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end
  wire logic ext_rise = ext_s2_q && !ext_s3_q;

  //------------------------------------------------------------
  // Run bit: software, external trigger, pulse stop
  //------------------------------------------------------------
  // Trigger outranks a stopping match, but the held count matches again and ends the pulse one cycle later
  wire logic run_d = (is_pulse && ext_rise) ? 1'b1
                   : wr_c0 ? pwdata_i[stm_pkg::CTRL0_RUN_BIT]
                   : (is_pulse && match_a) ? 1'b0
                   : run_q;
  wire logic run_rise = run_q && !run_prev_q;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_q      <= 1'b0;
      run_prev_q <= 1'b0;
    end else begin
      run_q      <= run_d;
      run_prev_q <= run_q;
    end
  end

  //------------------------------------------------------------
  // Counter
  //------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
    end else if (run_rise) begin
      cnt_q <= '0;
    end else if (run_q && tick_i && !(is_pulse && match_a)) begin
      cnt_q <= cnt_clear ? '0 : cnt_q + 1'b1;
    end
  end

  //------------------------------------------------------------
  // Match flags, set wins over write-one-to-clear
  //------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      af_q <= 1'b0;
      pf_q <= 1'b0;
    end else begin
      af_q <= set_af | (af_q & ~(wr_st & pwdata_i[stm_pkg::STAT_AF_BIT]));
      pf_q <= set_pf | (pf_q & ~(wr_st & pwdata_i[stm_pkg::STAT_PF_BIT]));
    end
  end

  //------------------------------------------------------------
  // Compare output level
  //------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_q <= 1'b0;
    end else if (run_rise) begin
      pin_q <= init_lvl;
    end else if (match_a) begin
      case (out_act)
        stm_pkg::ACT_LOW:    pin_q <= 1'b0;
        stm_pkg::ACT_HIGH:   pin_q <= 1'b1;
        stm_pkg::ACT_TOGGLE: pin_q <= ~pin_q;
        default:             pin_q <= pin_q;
      endcase
    end
  end

  //------------------------------------------------------------
  // PWM and pulse waveform
  //------------------------------------------------------------
  // Active while count is below duty; duty at or above period stays active
  wire logic pwm_act   = ({1'b0, cnt_q} < duty) || (duty >= period);
  wire logic wave_act  = is_pulse ? run_q : (run_q && pwm_act);
  wire logic wave_lvl  = init_lvl ? wave_act : ~wave_act;
  wire logic force_lvl = (out_act == stm_pkg::ACT_LOW) ? 1'b0 : 1'b1;
  wire logic m10_lvl   = (is_pulse || out_act == stm_pkg::ACT_PWM) ? wave_lvl
                                                                   : force_lvl;
  wire logic pin_d     = is_m10 ? m10_lvl : pin_q;

  // Registered pin; pulse trailing edge follows run bit clear
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= pin_d ^ out_inv;
    end
  end

  // Timer/counter mode releases the pin
  assign timer_out_o    = pwm_q;
  assign timer_out_en_o = !is_timer;
  assign match_a_flag_o = af_q;
  assign match_p_flag_o = pf_q;

  //------------------------------------------------------------
  // Control register writes
  //------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl0_q   <= stm_pkg::REG_RESET;
      ctrl1_q   <= stm_pkg::REG_RESET;
      cmpa_lo_q <= stm_pkg::REG_RESET;
      cmpa_hi_q <= 2'h0;
    end else begin
      if (wr_c0) ctrl0_q <= pwdata_i[7:0];
      if (wr_en && hit_c1) ctrl1_q <= pwdata_i[7:0];
      if (wr_en && hit_alo) cmpa_lo_q <= pwdata_i[7:0];
      if (wr_en && hit_ahi) cmpa_hi_q <= pwdata_i[1:0];
    end
  end

  //------------------------------------------------------------
  // Read mux
  //------------------------------------------------------------
  wire logic [7:0] ctrl0_rd = {ctrl0_q[7:4], run_q, ctrl0_q[2:0]};
  wire logic [7:0] cnt_hi_rd = {6'h00, cnt_q[CNT_W-1:8]};
  wire logic [7:0] st_rd    = {5'h00, pwm_q, pf_q, af_q};
  wire logic [7:0] rd_sel   = hit_c0  ? ctrl0_rd
                            : hit_c1  ? ctrl1_q
                            : hit_clo ? cnt_q[7:0]
                            : hit_chi ? cnt_hi_rd
                            : hit_alo ? cmpa_lo_q
                            : hit_ahi ? {6'h00, cmpa_hi_q}
                            : hit_st  ? st_rd
                            : 8'h00;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_o <= stm_pkg::RDATA_ZERO;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= {24'h000000, rd_sel};
    end
  end

endmodule : stm_timer

/* File: stm_pkg.sv */
// Package of constants for the standard timer mode logic
//------------------------------------------------------------
package stm_pkg;

  //------------------------------------------------------------
  // Register byte addresses
  //------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL0  = 8'h00;  // Run bit, compare P
  localparam logic [7:0] ADDR_CTRL1  = 8'h04;  // Mode and output control
  localparam logic [7:0] ADDR_CNT_LO = 8'h08;
  localparam logic [7:0] ADDR_CNT_HI = 8'h0c;
  localparam logic [7:0] ADDR_CMPA_LO = 8'h10;
  localparam logic [7:0] ADDR_CMPA_HI = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;  // Flags and pin, write 1 to clear a flag

  //------------------------------------------------------------
  // Field positions
  //------------------------------------------------------------
  localparam int CTRL0_RUN_BIT  = 3;
  localparam int CTRL0_CMPP_LSB = 0;
  localparam int CTRL1_MODE_LSB = 6;
  localparam int CTRL1_ACT_LSB  = 4;
  localparam int CTRL1_INIT_BIT = 3;
  localparam int CTRL1_INV_BIT  = 2;
  localparam int CTRL1_SWAP_BIT = 1;
  localparam int CTRL1_CLR_BIT  = 0;
  localparam int STAT_AF_BIT    = 0;
  localparam int STAT_PF_BIT    = 1;
  localparam int STAT_PIN_BIT   = 2;

  //------------------------------------------------------------
  // Encodings and widths
  //------------------------------------------------------------
  localparam logic [1:0] MODE_CMP   = 2'h0;
  localparam logic [1:0] MODE_PWM   = 2'h2;
  localparam logic [1:0] MODE_TIMER = 2'h3;
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_LOW    = 2'h1;
  localparam logic [1:0] ACT_HIGH   = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  localparam logic [1:0] ACT_PWM    = 2'h2;
  localparam logic [1:0] ACT_PULSE  = 2'h3;
  localparam int CNT_W  = 10;
  localparam int CMPP_W = 3;
  localparam logic [7:0]  REG_RESET = 8'h00;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage : stm_pkg

/* File: stm_chk.sv */
// Port-level checker for the standard timer, bound to its top module
module stm_chk #(
  parameter int CNT_W = stm_pkg::CNT_W
) (
  input wire logic        clock_i,
  input wire logic        rst_b_i,
  input wire logic        tick_i,
  input wire logic        external_clock_pin_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        timer_out_o,
  input wire logic        timer_out_en_o,
  input wire logic        match_a_flag_o,
  input wire logic        match_p_flag_o
);
  // ----------------------------------------
  // Configuration seen on the register bus
  // ----------------------------------------
  wire        acc  = psel_i & penable_i & pready_o;
  wire        wr0  = acc & pwrite_i & (paddr_i == stm_pkg::ADDR_CTRL0);
  wire        wr1  = acc & pwrite_i & (paddr_i == stm_pkg::ADDR_CTRL1);
  wire        wrs  = acc & pwrite_i & (paddr_i == stm_pkg::ADDR_STATUS);
  wire        rdhi = acc & !pwrite_i
                     & (paddr_i == stm_pkg::ADDR_CNT_HI | paddr_i == stm_pkg::ADDR_CMPA_HI);
  logic [7:0] ctl_q;
  logic       run_q;
  logic [3:0] hist_q;
  // Shadow of control writes; hist_q mutes pin checks while the pin pipeline settles
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctl_q  <= 8'h00;
      run_q  <= 1'h0;
      hist_q <= 4'h0;
    end else begin
      if (wr1) ctl_q <= pwdata_i[7:0];
      if (wr0) run_q <= pwdata_i[3];
      hist_q <= {hist_q[2:0], wr0 | wr1};
    end
  end
  wire [1:0]  mode  = ctl_q[7:6];
  wire        quiet = (hist_q == 4'h0);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  a_hi_bits_zero: assert property (rdhi |-> prdata_o[7:2] == 6'h00)
    else $error("high byte read shows unimplemented bits set");
  a_pin_enable: assert property (timer_out_en_o == (mode != stm_pkg::MODE_TIMER))
    else $error("pin enable does not follow the mode");
  a_a_sticky: assert property ($fell(match_a_flag_o) |-> $past(wrs & pwdata_i[0]))
    else $error("A flag dropped without a clear");
  a_p_sticky: assert property ($fell(match_p_flag_o) |-> $past(wrs & pwdata_i[1]))
    else $error("P flag dropped without a clear");
  a_no_p_flag: assert property ((mode[1] == mode[0]) && ctl_q[0] && quiet
    && !match_p_flag_o |=> !match_p_flag_o) else $error("P flag raised while A clears");
  a_run_init: assert property (wr0 && pwdata_i[3] && !run_q && !ctl_q[2]
    && mode == stm_pkg::MODE_CMP |-> ##[1:4] timer_out_o == ctl_q[3])
    else $error("pin not loaded with its initial level");
  a_cmp_no_act: assert property (mode == stm_pkg::MODE_CMP && ctl_q[5:4] == 2'h0
    && quiet |-> $stable(timer_out_o)) else $error("pin moved with no output action");
  a_pwm_forced: assert property (mode == stm_pkg::MODE_PWM && !ctl_q[5] && quiet
    |-> $stable(timer_out_o)) else $error("forced pin moved");
endmodule : stm_chk

bind stm_timer stm_chk #(.CNT_W(CNT_W)) stm_chk_inst (.clock_i(clock_i), .rst_b_i(rst_b_i),
  .tick_i(tick_i), .external_clock_pin_i(external_clock_pin_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .timer_out_o(timer_out_o),
  .timer_out_en_o(timer_out_en_o), .match_a_flag_o(match_a_flag_o),
  .match_p_flag_o(match_p_flag_o));

/* File: tb_top.sv */
// Self-checking bench for the standard timer mode logic
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [31:0] v; logic [31:0] m;} stm_exp_s;
  logic        clock_i = 1'h0;
  logic        rst_b_i = 1'h0;
  logic        tick = 1'h0;
  logic        trig = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, got;
  logic        pready, pslverr, pin, pin_en, af, pf;
  stm_exp_s    q[$];
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cyc = 0;
  event        got_ev;
  // PWM cases: action, invert, swap, compare P, compare A, period, high cycles (-1 flags)
  int          pw [4][7] = '{'{2, 0, 0, 1, 0, 128, 0}, '{2, 0, 0, 1, 200, 128, 128},
                             '{2, 1, 1, 2, 300, 300, 44}, '{0, 0, 0, 1, 60, 128, -1}};
  always #20 clock_i = ~clock_i;
  stm_timer stm_timer_inst (.clock_i(clock_i), .rst_b_i(rst_b_i), .tick_i(tick),
    .external_clock_pin_i(trig), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .timer_out_o(pin), .timer_out_en_o(pin_en),
    .match_a_flag_o(af), .match_p_flag_o(pf));
  // ----------------------------------------
  // Bus cycles, notes and comparisons
  // ----------------------------------------
  task automatic cmp(input logic [31:0] g);
    stm_exp_s e;
    e = q.pop_front();
    comparisons++;
    if ((g & e.m) !== (e.v & e.m)) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g & e.m, e.v & e.m);
    end
  endtask : cmp
  // Reads note their expectation; d is write data or expected read data
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, m);
    if (!w) q.push_back('{d, m});
    @(posedge clock_i);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'h1;
    do @(posedge clock_i); while (pready !== 1'h1);
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // A measured value goes to the watcher like a read answer
  task automatic chk(input logic [31:0] g, e);
    q.push_back('{e, 32'hffff_ffff});
    got = g;
    -> got_ev;
    #1;
  endtask : chk
  // Cycles until the pin leaves level v; bounded so a stuck pin cannot hang
  task automatic span(input logic v, output int n);
    n = 0;
    while (pin === v && n < 4000) begin
      @(negedge clock_i);
      n++;
    end
  endtask : span
  task automatic summarize();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // Watcher takes the oldest note for every read answer and measurement
  always @(posedge clock_i) if (psel && penable && pready === 1'h1 && !pwrite) cmp(prdata);
  always @(got_ev) cmp(got);
  // Hang guard, well above the few thousand cycles the sequence needs
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    int r, w, h;
    logic [1:0] md [3] = '{2'h0, 2'h2, 2'h3};
    r = $urandom(32'hefd5);
    repeat (12) @(posedge clock_i);
    rst_b_i <= 1'h1;
    apb(stm_pkg::ADDR_CTRL1, 0, 0, 32'hff);
    apb(stm_pkg::ADDR_STATUS, 0, 0, 32'h07);
    apb(stm_pkg::ADDR_CMPA_HI, 1, 32'hff, 0);
    apb(stm_pkg::ADDR_CMPA_HI, 0, 32'h03, 32'hff);
    apb(stm_pkg::ADDR_CNT_LO, 1, 32'h5a, 0);
    apb(stm_pkg::ADDR_CNT_LO, 0, 0, 32'hff);
    apb(8'h1c, 0, 0, 32'hffff_ffff);
    // Counter steps only on ticks, random pattern, cleared by the run rise
    apb(stm_pkg::ADDR_CTRL0, 1, 32'h08, 0);
    h = 0;
    repeat (60) begin
      @(posedge clock_i);
      r = $urandom % 2;
      tick <= r[0];
      h += r;
    end
    @(posedge clock_i);
    tick <= 1'h0;
    apb(stm_pkg::ADDR_CNT_LO, 0, h, 32'hff);
    foreach (md[i]) begin
      apb(stm_pkg::ADDR_CTRL1, 1, {24'h0, md[i], 6'h00}, 0);
      @(negedge clock_i);
      chk(pin_en, md[i] != stm_pkg::MODE_TIMER);
    end
    // Compare clear on P, clear on A with P below A, then timer mode
    tick <= 1'h1;
    for (int k = 0; k < 3; k++) begin
      r = (k == 1) ? 130 + $urandom % 60 : 10 + $urandom % 100;
      apb(stm_pkg::ADDR_CTRL0, 1, 32'h01, 0);
      apb(stm_pkg::ADDR_CMPA_LO, 1, r, 0);
      apb(stm_pkg::ADDR_CMPA_HI, 1, 0, 0);
      apb(stm_pkg::ADDR_CTRL1, 1, {24'h0, (k == 2) ? 2'h3 : 2'h0, 2'h3, k != 0, 2'h0, k != 0}, 0);
      apb(stm_pkg::ADDR_STATUS, 1, 32'h03, 0);
      apb(stm_pkg::ADDR_CTRL0, 1, 32'h09, 0);
      repeat (4) @(posedge clock_i);
      if (k < 2) begin
        span(pin, w);
        span(pin, w);
        chk(w, (k == 1 ? r : 128) + 1);
      end else
        repeat (2 * r + 10) @(posedge clock_i);
      apb(stm_pkg::ADDR_STATUS, 0, k ? 1 : 3, 32'h03);
    end
    // PWM duty, full duty, swapped and inverted, forced pin with flags
    foreach (pw[i]) begin
      if (i == 0) pw[0][4] = 1 + $urandom % 127;
      if (i == 0) pw[0][6] = pw[0][4];
      apb(stm_pkg::ADDR_CTRL0, 1, pw[i][3], 0);
      apb(stm_pkg::ADDR_CMPA_LO, 1, pw[i][4] % 256, 0);
      apb(stm_pkg::ADDR_CMPA_HI, 1, pw[i][4] / 256, 0);
      apb(stm_pkg::ADDR_CTRL1, 1, {24'h0, 2'h2, 2'(pw[i][0]), 1'h1, 1'(pw[i][1]),
          1'(pw[i][2]), 1'h0}, 0);
      apb(stm_pkg::ADDR_STATUS, 1, 32'h03, 0);
      apb(stm_pkg::ADDR_CTRL0, 1, 8 + pw[i][3], 0);
      repeat (pw[i][5] + 8) @(negedge clock_i);
      h = 0;
      repeat (2 * pw[i][5]) begin
        @(negedge clock_i);
        h += (pin === 1'h1);
      end
      if (pw[i][6] >= 0)
        chk(h, 2 * pw[i][6]);
      else
        apb(stm_pkg::ADDR_STATUS, 0, 3, 32'h03);
    end
    // Single pulse from the pin edge, then from software
    apb(stm_pkg::ADDR_CTRL0, 1, 0, 0);
    apb(stm_pkg::ADDR_CMPA_LO, 1, 40, 0);
    apb(stm_pkg::ADDR_CMPA_HI, 1, 0, 0);
    apb(stm_pkg::ADDR_CTRL1, 1, 32'hb8, 0);
    repeat (4) @(posedge clock_i);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) begin
        @(posedge clock_i);
        trig <= 1'h1;
        repeat (4) @(posedge clock_i);
        trig <= 1'h0;
      end else
        apb(stm_pkg::ADDR_CTRL0, 1, 32'h08, 0);
      span(1'h0, w);
      span(1'h1, w);
      chk(w >= 40 && w <= 43, 1);
      apb(stm_pkg::ADDR_CTRL0, 0, 0, 32'h08);
    end
    summarize();
  end
endmodule : tb_top
